// file: rtl/radio_dev.sv
/*
 * Device end of the radio configuration slice: SPI slave with the
 * listen timing, gain, correction offset, control and version registers,
 * RC calibration at power-up and the reference clock output.
 * Assumes SPI mode 0 with sck at most ref_clk / 16 and a host that keeps
 * its power-on and manual reset timing.
 */
`timescale 1ns/1ps
`include "radio_params.svh"

// What this block does
// [R1] Gain code 0x1B normal, 0x2D high
// [R2] Offset resets zero, used only when enabled
// [R3] Applied offset is register times 488 Hz
// [R4] Host waits 10 ms after power-on, or less once the clock output toggles
// [R5] Host leaves reset pin floating at power-on
// [R6] Host pulses reset pin high about 100 us
// [R7] Host waits 5 ms after manual reset
// [R8] Clock output runs only once ready
// [R9] Read-only version code at address 0x10
// [R10] Idle time unit in bits 7-6, reset 10
// [R11] Receive time unit in bits 5-4, reset 01
// [R12] Clearing listen enable leaves listen mode
// [R13] RC calibration runs by itself at power-up
// [R14] One address byte, one data byte per access
module radio_dev (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Pins toward the host
    radio_link_if.dev link,
    // Radio core controls
    output logic receiver_gain_level,
    output logic gain_code_known,
    output logic [16:0] applied_offset_hz,
    output logic [1:0] idle_phase_time_unit,
    output logic [1:0] receive_phase_time_unit,
    output logic duty_cycled_receive_enable,
    output logic low_index_correction_enable,
    output logic rc_cal_done
);

    // Reset image of the whole state
    localparam radio_pkg::dev_state_s DEV_RST = '{
        listen: `LISTEN_RST,
        gain: `GAIN_RST,
        offset: `OFFSET_RST,
        ctrl: `CTRL_RST,
        st: radio_pkg::DST_CAL,
        nss_s1: 1'b1,
        nss_s2: 1'b1,
        default: '0
    };
    localparam logic [11:0] CAL_LAST = 12'(`CAL_CYC - 1);
    localparam logic [3:0] CLK_LAST = 4'(`REFERENCE_CLOCK_OUTPUT_HALF - 1);
    localparam logic [16:0] STEP_HZ = 17'(`OFFSET_STEP_HZ);

    radio_pkg::dev_state_s r_reg;
    radio_pkg::dev_state_s r_next;

    logic sck_rise;
    logic sck_fall;
    logic [7:0] rx_byte;

    // Register read decode, used only by the read path
    function automatic logic [7:0] reg_read(
        input logic [6:0] a,
        input radio_pkg::dev_state_s s
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `ADDR_LISTEN: v = s.listen;
            `ADDR_GAIN: v = s.gain;
            `ADDR_OFFSET: v = s.offset;
            `ADDR_CTRL: v = {6'h00, s.ctrl};
            `ADDR_VERSION: v = `VERSION_CODE; // [R9]
            default: v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    // Edges of the synchronised serial clock
    assign sck_rise = r_reg.sck_s2 & ~r_reg.sck_s3;
    assign sck_fall = ~r_reg.sck_s2 & r_reg.sck_s3;
    assign rx_byte = {r_reg.rx_sh[6:0], r_reg.mosi_s2};

    // Next state of the whole device
    always_comb begin
        r_next = r_reg;

        // Two-stage synchronisers on every pin input
        r_next.sck_s1 = link.sck;
        r_next.sck_s2 = r_reg.sck_s1;
        r_next.sck_s3 = r_reg.sck_s2;
        r_next.nss_s1 = link.nss_n;
        r_next.nss_s2 = r_reg.nss_s1;
        r_next.mosi_s1 = link.mosi;
        r_next.mosi_s2 = r_reg.mosi_s1;
        r_next.rst_s1 = link.rst_pin;
        r_next.rst_s2 = r_reg.rst_s1;

        // Life cycle: calibrate, then ready, held while reset pin high
        case (r_reg.st)
            radio_pkg::DST_CAL: begin
                r_next.cal_cnt = r_reg.cal_cnt + 12'h001;
                if (r_reg.cal_cnt == CAL_LAST) begin // [R13]
                    r_next.st = radio_pkg::DST_READY;
                    r_next.cal_cnt = 12'h000;
                end
            end
            radio_pkg::DST_READY: begin
                // Clock output toggles only while ready
                r_next.div = r_reg.div + 4'h1;
                if (r_reg.div == CLK_LAST) begin // [R8]
                    r_next.div = 4'h0;
                    r_next.clk_out = ~r_reg.clk_out;
                end
            end
            radio_pkg::DST_HELD: begin
                r_next.div = 4'h0;
                r_next.clk_out = 1'b0;
                r_next.cal_cnt = 12'h000;
                if (!r_reg.rst_s2) begin
                    r_next.st = radio_pkg::DST_CAL; // [R13]
                end
            end
            default: r_next.st = radio_pkg::DST_CAL;
        endcase

        // Serial frame: one command byte, then one data byte
        if (r_reg.nss_s2 || r_reg.st != radio_pkg::DST_READY) begin
            r_next.bit_cnt = 5'h00;
            r_next.miso = 1'b0;
        end else begin
            if (sck_rise && r_reg.bit_cnt != 5'h10) begin // [R14]
                r_next.rx_sh = rx_byte;
                r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
                if (r_reg.bit_cnt == 5'h07) begin
                    r_next.cmd = rx_byte;
                    r_next.tx_sh = reg_read(rx_byte[6:0], r_reg);
                end
                if (r_reg.bit_cnt == 5'h0F && r_reg.cmd[`CMD_WRITE]) begin
                    case (r_reg.cmd[6:0])
                        `ADDR_LISTEN: r_next.listen = rx_byte; // [R10] [R11]
                        `ADDR_GAIN: r_next.gain = rx_byte; // [R1]
                        `ADDR_OFFSET: r_next.offset = rx_byte; // [R2]
                        `ADDR_CTRL: r_next.ctrl = rx_byte[1:0]; // [R12]
                        default: r_next.cmd = r_reg.cmd;
                    endcase
                end
            end
            // Read data leaves on falling edges, most significant first
            if (sck_fall && r_reg.bit_cnt >= 5'h08) begin
                r_next.miso = r_reg.tx_sh[7];
                r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
            end
        end

        // Manual reset pin forces registers back to their reset values
        if (r_reg.rst_s2) begin
            r_next.st = radio_pkg::DST_HELD;
            r_next.listen = `LISTEN_RST; // [R10] [R11]
            r_next.gain = `GAIN_RST;
            r_next.offset = `OFFSET_RST; // [R2]
            r_next.ctrl = `CTRL_RST;
            r_next.bit_cnt = 5'h00;
            r_next.miso = 1'b0;
        end

        // Decoded controls toward the radio core
        r_next.gain_lvl = (r_reg.gain == `GAIN_HIGH); // [R1]
        r_next.gain_known = (r_reg.gain == `GAIN_HIGH) ||
            (r_reg.gain == `GAIN_NORMAL); // [R1]
        if (r_reg.ctrl[`CTRL_CORR]) begin
            r_next.offset_hz = 17'(r_reg.offset) * STEP_HZ; // [R3]
        end else begin
            r_next.offset_hz = 17'h00000; // [R2]
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= DEV_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Pin outputs
    assign link.miso = r_reg.miso;
    assign link.reference_clock_output = r_reg.clk_out; // [R8]

    // Core control outputs
    assign receiver_gain_level = r_reg.gain_lvl;
    assign gain_code_known = r_reg.gain_known;
    assign applied_offset_hz = r_reg.offset_hz;
    assign idle_phase_time_unit = r_reg.listen[`IDLE_MSB:`IDLE_LSB];
    assign receive_phase_time_unit = r_reg.listen[`RXU_MSB:`RXU_LSB];
    // Listen mode ends as soon as the enable bit clears
    assign duty_cycled_receive_enable = r_reg.ctrl[`CTRL_LISTEN]; // [R12]
    assign low_index_correction_enable = r_reg.ctrl[`CTRL_CORR];
    assign rc_cal_done = (r_reg.st == radio_pkg::DST_READY);

endmodule : radio_dev

// file: rtl/radio_params.svh
/*
 * Constants for the radio configuration slice and its host controller:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 200 MHz ref_clk on both ends.
 */
`ifndef RADIO_PARAMS_SVH
`define RADIO_PARAMS_SVH

// Clock rate
`define CLK_MHZ 200

// Device register offsets (7-bit SPI address)
`define ADDR_LISTEN 7'h0D
`define ADDR_VERSION 7'h10
`define ADDR_CTRL 7'h60
`define ADDR_GAIN 7'h58
`define ADDR_OFFSET 7'h71

// Device reset values
`define LISTEN_RST 8'h90
`define GAIN_RST 8'h1B
`define OFFSET_RST 8'h00
`define CTRL_RST 2'h0
// Version code, value is arbitrary
`define VERSION_CODE 8'h5A

// Field positions
`define IDLE_MSB 7
`define IDLE_LSB 6
`define RXU_MSB 5
`define RXU_LSB 4
`define CTRL_LISTEN 0
`define CTRL_CORR 1
`define CMD_WRITE 7

// Gain codes and time units
`define GAIN_NORMAL 8'h1B
`define GAIN_HIGH 8'h2D
`define UNIT_64US 2'h1
`define UNIT_4MS 2'h2
`define UNIT_262MS 2'h3

// Frequency correction step in Hz
`define OFFSET_STEP_HZ 488

// Device timing
`define CAL_TIME_US 5
`define CAL_CYC (`CAL_TIME_US * `CLK_MHZ)
`define REFERENCE_CLOCK_OUTPUT_HALF 4

// Host timing
`define POR_WAIT_MS 10
`define POR_WAIT_CYC (`POR_WAIT_MS * 1000 * `CLK_MHZ)
`define RST_PULSE_US 100
`define RST_PULSE_CYC (`RST_PULSE_US * `CLK_MHZ)
`define RST_WAIT_MS 5
`define RST_WAIT_CYC (`RST_WAIT_MS * 1000 * `CLK_MHZ)
`define SCK_HALF 8

// Host Avalon register offsets (byte addresses)
`define HREG_CMD 4'h0
`define HREG_STATUS 4'h4
`define HREG_RESET 4'h8

`endif

// file: rtl/radio_pkg.sv
/*
 * Types shared by the radio device and host ends: state enums and
 * the packed state records of each end.
 * Assumes radio_params.svh is on the include path.
 */
package radio_pkg;

    // Device life cycle, Gray along cal -> ready -> held
    typedef enum logic [1:0] {
        DST_CAL = 2'h0,
        DST_READY = 2'h1,
        DST_HELD = 2'h3
    } dev_st_e;

    // Host sequencing, Gray along the usual path
    typedef enum logic [2:0] {
        HST_POR = 3'h0,
        HST_IDLE = 3'h1,
        HST_XFER = 3'h3,
        HST_RDRV = 3'h2,
        HST_RWAIT = 3'h6
    } host_st_e;

    // Whole device state
    typedef struct packed {
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic nss_s1;
        logic nss_s2;
        logic mosi_s1;
        logic mosi_s2;
        logic rst_s1;
        logic rst_s2;
        logic [4:0] bit_cnt;
        logic [7:0] rx_sh;
        logic [7:0] cmd;
        logic [7:0] tx_sh;
        logic miso;
        logic [7:0] listen;
        logic [7:0] gain;
        logic [7:0] offset;
        logic [1:0] ctrl;
        dev_st_e st;
        logic [11:0] cal_cnt;
        logic [3:0] div;
        logic clk_out;
        logic gain_lvl;
        logic gain_known;
        logic [16:0] offset_hz;
    } dev_state_s;

    // Whole host state
    typedef struct packed {
        logic miso_s1;
        logic miso_s2;
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        host_st_e st;
        logic [21:0] cnt;
        logic [3:0] div;
        logic [4:0] bit_cnt;
        logic [15:0] sh;
        logic smp;
        logic [7:0] rdata;
        logic sck;
        logic nss_n;
        logic rst_o;
        logic ack;
        logic [31:0] rd_q;
    } host_state_s;

endpackage : radio_pkg

// file: rtl/radio_link_if.sv
/*
 * Pins between the radio device and its host: SPI, reset pin and the
 * reference clock output.
 * Assumes the reset pin is pulled low when nobody drives it.
 */
`timescale 1ns/1ps
interface radio_link_if;
    logic sck;
    logic nss_n;
    logic mosi;
    logic miso;
    logic rst_pin_o;
    logic rst_pin_oe;
    logic rst_pin;
    logic reference_clock_output;

    // Resolved reset pin level, floating reads low
    assign rst_pin = rst_pin_oe & rst_pin_o;

    modport dev (
        input sck, nss_n, mosi, rst_pin,
        output miso, reference_clock_output
    );

    modport host (
        output sck, nss_n, mosi, rst_pin_o, rst_pin_oe,
        input miso, reference_clock_output
    );
endinterface : radio_link_if

// file: rtl/radio_host.sv
/*
 * Host end: Avalon-MM slave for software, SPI master toward the device,
 * power-on wait and manual reset sequencing on the reset pin.
 * Assumes the device answers SPI mode 0 with one address byte.
 */
`timescale 1ns/1ps
`include "radio_params.svh"

module radio_host #(
    parameter int POR_WAIT_CYC = `POR_WAIT_CYC,
    parameter int RST_PULSE_CYC = `RST_PULSE_CYC,
    parameter int RST_WAIT_CYC = `RST_WAIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins toward the device
    radio_link_if.host link
);

    localparam radio_pkg::host_state_s HOST_RST = '{
        st: radio_pkg::HST_POR,
        nss_n: 1'b1,
        default: '0
    };
    localparam logic [21:0] POR_LAST = 22'(POR_WAIT_CYC - 1);
    localparam logic [21:0] PULSE_LAST = 22'(RST_PULSE_CYC - 1);
    localparam logic [21:0] WAIT_LAST = 22'(RST_WAIT_CYC - 1);
    localparam logic [3:0] HALF_LAST = 4'(`SCK_HALF - 1);

    radio_pkg::host_state_s r_reg;
    radio_pkg::host_state_s r_next;

    logic req;
    logic taken;
    logic ready;
    logic busy;

    // Bus handshake: one wait cycle, then the access is taken
    assign req = avs_read | avs_write;
    assign taken = req & r_reg.ack;
    assign avs_waitrequest = req & ~r_reg.ack;
    assign avs_readdata = r_reg.rd_q;
    assign ready = (r_reg.st == radio_pkg::HST_IDLE) ||
        (r_reg.st == radio_pkg::HST_XFER);
    assign busy = (r_reg.st != radio_pkg::HST_IDLE);

    // Next state of the whole host
    always_comb begin
        r_next = r_reg;
        r_next.miso_s1 = link.miso;
        r_next.miso_s2 = r_reg.miso_s1;
        r_next.clk_s1 = link.reference_clock_output;
        r_next.clk_s2 = r_reg.clk_s1;
        r_next.clk_s3 = r_reg.clk_s2;
        r_next.ack = req & ~r_reg.ack;
        r_next.cnt = r_reg.cnt + 22'h000001;

        // Read data is latched in the wait cycle
        if (avs_read && !r_reg.ack) begin
            case (avs_address)
                `HREG_STATUS: r_next.rd_q = {16'h0000, r_reg.rdata,
                    6'h00, ready, busy};
                default: r_next.rd_q = 32'h00000000;
            endcase
        end

        // Power-on, manual reset and transfer sequencing
        case (r_reg.st)
            radio_pkg::HST_POR: begin
                // Pin floats; clock activity also means ready
                if (r_reg.cnt == POR_LAST ||
                    (r_reg.clk_s2 ^ r_reg.clk_s3)) begin // [R4] [R5] [R8]
                    r_next.st = radio_pkg::HST_IDLE;
                end
            end
            radio_pkg::HST_IDLE: begin
                if (taken && avs_write && avs_address == `HREG_CMD) begin
                    r_next.st = radio_pkg::HST_XFER; // [R14]
                    r_next.sh = avs_writedata[15:0];
                    r_next.nss_n = 1'b0;
                    r_next.div = 4'h0;
                    r_next.bit_cnt = 5'h00;
                end else if (taken && avs_write &&
                    avs_address == `HREG_RESET && avs_writedata[0]) begin
                    r_next.st = radio_pkg::HST_RDRV;
                    r_next.rst_o = 1'b1; // [R6]
                    r_next.cnt = 22'h000000;
                end
            end
            radio_pkg::HST_XFER: begin
                r_next.div = r_reg.div + 4'h1;
                if (r_reg.div == HALF_LAST) begin
                    r_next.div = 4'h0;
                    r_next.sck = ~r_reg.sck;
                    if (!r_reg.sck) begin
                        r_next.smp = r_reg.miso_s2;
                    end else begin
                        r_next.sh = {r_reg.sh[14:0], r_reg.smp};
                        r_next.bit_cnt = r_reg.bit_cnt + 5'h01;
                        if (r_reg.bit_cnt == 5'h0F) begin
                            r_next.rdata = {r_reg.sh[6:0], r_reg.smp};
                            r_next.nss_n = 1'b1;
                            r_next.st = radio_pkg::HST_IDLE;
                        end
                    end
                end
            end
            radio_pkg::HST_RDRV: begin
                if (r_reg.cnt == PULSE_LAST) begin
                    r_next.rst_o = 1'b0; // [R6]
                    r_next.cnt = 22'h000000;
                    r_next.st = radio_pkg::HST_RWAIT;
                end
            end
            radio_pkg::HST_RWAIT: begin
                if (r_reg.cnt == WAIT_LAST) begin // [R7]
                    r_next.st = radio_pkg::HST_IDLE;
                end
            end
            default: r_next.st = radio_pkg::HST_POR;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_reg <= HOST_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Pin outputs; reset pin driven only during the pulse
    assign link.sck = r_reg.sck;
    assign link.nss_n = r_reg.nss_n;
    assign link.mosi = r_reg.sh[15];
    assign link.rst_pin_o = r_reg.rst_o;
    assign link.rst_pin_oe = r_reg.rst_o; // [R5] [R6]

endmodule : radio_host

// file: dv/radio_link_monitor.sv
/*
 * Checker on the pins between the radio device and its host.
 * Assumes one ref_clk domain and the pin signals of the link interface.
 */
`timescale 1ns/1ps
module radio_link_monitor #(
    parameter int POR_WAIT_CYC = 1200,
    parameter int RST_PULSE_CYC = 20,
    parameter int RST_WAIT_CYC = 1200
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link pins
    input wire logic sck,
    input wire logic nss_n,
    input wire logic mosi,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe,
    input wire logic reference_clock_output
);
    int boot_cnt;
    int quiet_cnt;
    int pulse_cnt;
    int edge_cnt;
    logic sck_d;
    logic clk_seen;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Cycles since reset and since pin release, pulse length, sck rises
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_cnt <= 0;
            quiet_cnt <= 1 << 20;
            pulse_cnt <= 0;
            edge_cnt <= 0;
            sck_d <= 1'b0;
            clk_seen <= 1'b0;
        end else begin
            boot_cnt <= (boot_cnt < (1 << 20)) ? boot_cnt + 1 : boot_cnt;
            quiet_cnt <= rst_pin_oe ? 0 : quiet_cnt + 1;
            pulse_cnt <= rst_pin_oe ? pulse_cnt + 1 : 0;
            edge_cnt <= nss_n ? 0 : edge_cnt + int'(sck & ~sck_d);
            sck_d <= sck;
            clk_seen <= clk_seen | reference_clock_output;
        end
    end

    property p_por_float;
        (boot_cnt < POR_WAIT_CYC && !clk_seen) |-> !rst_pin_oe;
    endproperty
    a_por_float: assert property (p_por_float)
        else $error("reset pin driven during power-on wait");

    property p_por_wait;
        !nss_n |-> (boot_cnt >= POR_WAIT_CYC || clk_seen);
    endproperty
    a_por_wait: assert property (p_por_wait)
        else $error("frame started before power-on wait ended");

    property p_pulse_len;
        $fell(rst_pin_oe) |->
            (pulse_cnt >= RST_PULSE_CYC && pulse_cnt <= RST_PULSE_CYC + 2);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("reset pulse length wrong");

    property p_pulse_high;
        rst_pin_oe |-> rst_pin_o;
    endproperty
    a_pulse_high: assert property (p_pulse_high)
        else $error("reset pin driven low");

    property p_rst_wait;
        !nss_n |-> quiet_cnt >= RST_WAIT_CYC - 2;
    endproperty
    a_rst_wait: assert property (p_rst_wait)
        else $error("frame too soon after manual reset");

    property p_clk_boot;
        boot_cnt < 1000 |-> !reference_clock_output;
    endproperty
    a_clk_boot: assert property (p_clk_boot)
        else $error("clock output active during calibration");

    property p_clk_held;
        (rst_pin_oe & rst_pin_o) [*6] |-> !reference_clock_output;
    endproperty
    a_clk_held: assert property (p_clk_held)
        else $error("clock output active while held in reset");

    property p_frame_len;
        $rose(nss_n) |-> edge_cnt == 16;
    endproperty
    a_frame_len: assert property (p_frame_len)
        else $error("frame is not sixteen bits");

    property p_sck_idle;
        nss_n |-> !sck;
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("sck high outside a frame");

    property p_sck_half;
        $rose(sck) |-> sck [*8] ##1 !sck;
    endproperty
    a_sck_half: assert property (p_sck_half)
        else $error("sck high phase not eight cycles");

    property p_mosi_hold;
        (!nss_n && sck && $past(sck)) |-> $stable(mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("mosi moved while sck high");

    // Main scenarios reached
    c_frame: cover property ($rose(nss_n));
    c_pulse: cover property ($fell(rst_pin_oe));
    c_clk: cover property ($rose(reference_clock_output));
endmodule : radio_link_monitor

// file: dv/tb_radio_test_listen_config.sv
/*
 * Testbench: host and device joined by the link interface; software
 * side driven over Avalon-MM, device outputs compared with expectations.
 * Assumes a 200 MHz ref_clk and shortened host wait counts.
 */
`timescale 1ns/1ps
`include "radio_params.svh"
module tb_radio_test_listen_config;
    localparam int POR_CYC = 1200;
    localparam int PULSE_CYC = 20;
    localparam int WAIT_CYC = 1200;
    // Stimulus and observed outputs
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic gain_lvl, gain_known, listen_en, corr_en, cal_done;
    logic [16:0] off_hz;
    logic [1:0] idle_u, rx_u;
    logic [31:0] q;
    logic [7:0] b, v;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;

    radio_link_if radio_link_if_i ();
    radio_dev radio_dev_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .link(radio_link_if_i), .receiver_gain_level(gain_lvl),
        .gain_code_known(gain_known), .applied_offset_hz(off_hz),
        .idle_phase_time_unit(idle_u), .receive_phase_time_unit(rx_u),
        .duty_cycled_receive_enable(listen_en),
        .low_index_correction_enable(corr_en), .rc_cal_done(cal_done));
    radio_host #(.POR_WAIT_CYC(POR_CYC), .RST_PULSE_CYC(PULSE_CYC),
        .RST_WAIT_CYC(WAIT_CYC)) radio_host_i (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link(radio_link_if_i));
    radio_link_monitor #(.POR_WAIT_CYC(POR_CYC), .RST_PULSE_CYC(PULSE_CYC),
        .RST_WAIT_CYC(WAIT_CYC)) radio_link_monitor_i (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .sck(radio_link_if_i.sck),
        .nss_n(radio_link_if_i.nss_n), .mosi(radio_link_if_i.mosi),
        .rst_pin_o(radio_link_if_i.rst_pin_o),
        .rst_pin_oe(radio_link_if_i.rst_pin_oe),
        .reference_clock_output(radio_link_if_i.reference_clock_output));

    // Clock
    always #2.5 ref_clk = ~ref_clk;

    // Hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            $display("[FAIL] %0t run timed out", $time);
            results();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // One Avalon cycle, held until waitrequest is low
    task av(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av

    task poll(input logic [31:0] m, input logic [31:0] want);
        int n;
        n = 0;
        do begin
            av(`HREG_STATUS, 1'b0, 32'h0);
            n++;
        end while ((q & m) !== want && n < 5000);
        if ((q & m) !== want) begin
            err_count++;
            $display("[FAIL] %0t status poll timed out", $time);
        end
    endtask : poll

    // One device access over SPI; read byte lands in b
    task spi(input logic w, input logic [6:0] a, input logic [7:0] d);
        poll(32'h1, 32'h0);
        av(`HREG_CMD, 1'b1, {16'h0, w, a, d});
        poll(32'h1, 32'h0);
        b = q[15:8];
    endtask : spi

    function automatic logic [16:0] exp_hz(logic [7:0] o, logic en);
        return en ? 17'(o * 17'h1E8) : 17'h0;
    endfunction : exp_hz

    task results;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        v = 8'($urandom(10));
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge ref_clk);
        check(idle_u, 2'h2, "idle unit reset");
        check(rx_u, 2'h1, "rx unit reset");
        check(off_hz, 17'h0, "offset reset");
        check(gain_known, 1'b1, "gain code reset");
        check(cal_done, 1'b0, "calibrating");
        poll(32'h2, 32'h2);
        check(cal_done, 1'b1, "calibrated");
        spi(1'b0, `ADDR_LISTEN, 8'h00);
        check(b, 8'h90, "listen reg reset");
        spi(1'b0, `ADDR_OFFSET, 8'h00);
        check(b, 8'h00, "offset reg reset");
        spi(1'b0, `ADDR_VERSION, 8'h00);
        check(b, `VERSION_CODE, "version");
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h2D : (i == 1) ? 8'h1B : 8'($urandom);
            spi(1'b1, `ADDR_GAIN, v);
            spi(1'b0, `ADDR_GAIN, 8'h00);
            check(b, v, "gain readback");
            check(gain_lvl, v === 8'h2D, "gain level");
            check(gain_known, v === 8'h1B || v === 8'h2D, "known");
        end
        $display("test gain done");
        for (int i = 0; i < 6; i++) begin
            v = (i < 2) ? 8'hFF : 8'($urandom);
            spi(1'b1, `ADDR_CTRL, {6'h0, i[0], 1'b0});
            spi(1'b1, `ADDR_OFFSET, v);
            spi(1'b0, `ADDR_OFFSET, 8'h00);
            check(b, v, "offset readback");
            check(corr_en, i[0], "correction enable");
            check(off_hz, exp_hz(v, i[0]), "applied offset");
        end
        $display("test offset done");
        for (int i = 0; i < 16; i++) begin
            v = {i[3:0], 4'($urandom)};
            spi(1'b1, `ADDR_LISTEN, v);
            spi(1'b0, `ADDR_LISTEN, 8'h00);
            check(b, v, "listen readback");
            check(idle_u, v[7:6], "idle unit");
            check(rx_u, v[5:4], "rx unit");
        end
        $display("test listen_units done");
        spi(1'b1, `ADDR_CTRL, 8'h01);
        check(listen_en, 1'b1, "listen on");
        spi(1'b1, `ADDR_CTRL, 8'h00);
        check(listen_en, 1'b0, "listen off");
        $display("test listen_exit done");
        spi(1'b1, `ADDR_VERSION, ~`VERSION_CODE);
        spi(1'b0, `ADDR_VERSION, 8'h00);
        check(b, `VERSION_CODE, "version read only");
        spi(1'b0, 7'h20, 8'h00);
        check(b, 8'h00, "unmapped device read");
        av(4'hC, 1'b0, 32'h0);
        check(q, 32'h0, "unmapped host read");
        $display("test read_only done");
        spi(1'b1, `ADDR_GAIN, 8'h2D);
        spi(1'b1, `ADDR_LISTEN, 8'h5F);
        av(`HREG_RESET, 1'b1, 32'h1);
        poll(32'h3, 32'h2);
        check(gain_lvl, 1'b0, "gain after reset");
        check(idle_u, 2'h2, "idle unit after reset");
        check(cal_done, 1'b1, "recalibrated");
        spi(1'b0, `ADDR_LISTEN, 8'h00);
        check(b, 8'h90, "listen after reset");
        $display("test manual_reset done");
        results();
    end
endmodule : tb_radio_test_listen_config
